// *** hw/smlx_pkg.sv ***
// Shared constants and types of the serial memory lane controller
package smlx_pkg;
  // Transfer width codes of the slot control word
  localparam logic [2:0] W_SINGLE = 3'h0;
  localparam logic [2:0] W_DUAL = 3'h1;
  localparam logic [2:0] W_QUAD = 3'h2;
  localparam logic [2:0] W_DQUAD = 3'h3;
  localparam logic [2:0] W_OCTAL = 3'h4;
  // Slot control field positions
  localparam int SC_WIDTH_LSB = 0;
  localparam int SC_GROUP_LSB = 4;
  localparam int SC_CRYPT_BIT = 8;
  localparam int SC_BITS = 16;
  // Lane group codes
  localparam logic [1:0] LANE_GROUP_ZERO = 2'h0;
  localparam logic [1:0] LANE_GROUP_TWO = 2'h2;
  // Frame layout, opcodes and cipher constants
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [6:0] HEAD_BITS = 7'h20;
  localparam logic [6:0] FRAME_BITS = 7'h40;
  localparam logic [3:0] AES_ROUNDS = 4'ha;
  localparam logic [7:0] RCON_FIRST = 8'h01;
  localparam logic [7:0] GF_POLY = 8'h1b;
  localparam logic [7:0] SBOX_AFFINE = 8'h63;
  // Reset values
  localparam logic [127:0] KEY_RESET = 128'h0;
  localparam logic [31:0] EXT_RESET = 32'h0000_0000;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} smlx_state_t;
endpackage

// *** hw/smlx_sbox.sv ***
// Cipher substitution box computed from field inverse and affine map
`timescale 1ns/1ps
module smlx_sbox import smlx_pkg::*; (
  input wire logic [7:0] byte_in,
  output logic [7:0] byte_out
);
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h00;
    p = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r = r ^ p;
      p = {p[6:0], 1'b0} ^ (p[7] ? GF_POLY : 8'h00);
    end
    return r;
  endfunction
  logic [7:0] inv;
  logic [7:0] pw;
  always_comb begin
    inv = 8'h01;
    pw = byte_in;
    // Product of x^2 .. x^128 gives x^254, the inverse
    for (int i = 0; i < 7; i++) begin
      pw = gf_mul(pw, pw);
      inv = gf_mul(inv, pw);
    end
    byte_out = inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]}
      ^ {inv[4:0], inv[7:5]} ^ {inv[3:0], inv[7:4]} ^ SBOX_AFFINE;
  end
endmodule // smlx_sbox

// *** hw/smlx_ctrl.sv ***
// Serial memory lane controller with address keystream cipher
// Operation
// - Controller is always master, driving serial clock and every chip select.
// - Clock idles low; sample on rising edge, change data on falling edge.
// - Widths one, two, four, paired four and eight lanes, chosen per slot.
// - One bit per lane per serial clock; no double data rate.
// - Eight data lanes and four chip-select slots.
// - Each slot owns one select; an access asserts only that select, except paired four-lane, which also asserts the next slot's.
// - A device's lanes form one contiguous group.
// - Groups one or two lanes use 2n and 2n+1; single: out low, in high.
// - Four-lane devices use group zero or two; groups one and three illegal.
// - Eight-lane devices use group zero only; shared lanes need distinct selects.
// - Paired four-lane: device 0 lanes 0-3, device 1 lanes 4-7, one nibble each.
// - Paired devices share serial clock, with separate selects and lanes.
// - Block cipher with 128-bit key in four write-only key registers.
// - Cipher applies automatically to fetches and memory reads and writes.
// - Cipher input is address 31:4 extended by four input registers.
// - Keystream XORs transfer data both ways without delaying the transfer.
// - Slot control bit 8 enables the cipher for that slot.
// - Mapped bus accesses become serial transfers without software commands.
`timescale 1ns/1ps
module smlx_ctrl import smlx_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic if_clk_in,
  input wire logic xip_req_in,
  input wire logic xip_write_in,
  input wire logic [1:0] xip_slot_in,
  input wire logic [31:0] xip_addr_in,
  input wire logic [31:0] xip_wdata_in,
  input wire logic [63:0] slot_control_in,
  input wire logic key_wr_in,
  input wire logic [1:0] key_sel_in,
  input wire logic [31:0] key_data_in,
  input wire logic ext_wr_in,
  input wire logic [1:0] ext_sel_in,
  input wire logic [31:0] ext_data_in,
  input wire logic [7:0] dq_in,
  output logic xip_busy_out,
  output logic xip_done_out,
  output logic xip_err_out,
  output logic [31:0] xip_rdata_out,
  output logic sck_out,
  output logic [3:0] cs_n_out,
  output logic [7:0] dq_out,
  output logic [7:0] dq_oe_out
);
  function automatic logic [3:0] lanes_of(input logic [2:0] w);
    return (w == W_SINGLE) ? 4'h1 : (w == W_DUAL) ? 4'h2 : (w == W_QUAD) ? 4'h4 : 4'h8;
  endfunction
  function automatic logic [7:0] lane_drive(input logic [7:0] t, input logic [3:0] k,
                                            input logic [2:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int j = 0; j < 8; j++) begin
      if (j < k) r[3'(b + j)] = t[3'(8 - k + j)];
    end
    return r;
  endfunction
  function automatic logic [7:0] lane_mask(input logic [3:0] k, input logic [2:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int j = 0; j < 8; j++) begin
      if (j < k) r[3'(b + j)] = 1'b1;
    end
    return r;
  endfunction
  function automatic logic [7:0] lane_gather(input logic [7:0] d, input logic [3:0] k,
                                             input logic [2:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int j = 0; j < 8; j++) begin
      if (j < k) r[j] = d[3'(b + j)];
    end
    if (k == 4'h1) r[0] = d[3'(b + 1)];
    return r;
  endfunction
  function automatic logic [7:0] xt(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? GF_POLY : 8'h00);
  endfunction

  smlx_state_t state_reg;
  logic [1:0] ck_sync_reg;
  logic ck_prev_reg;
  logic [7:0] dq_meta_reg;
  logic [7:0] dq_sync_reg;
  logic sck_reg;
  logic [3:0] cs_n_reg;
  logic [7:0] dq_reg;
  logic [7:0] oe_reg;
  logic busy_reg;
  logic done_reg;
  logic err_reg;
  logic [31:0] rdata_reg;
  logic [6:0] cnt_reg;
  logic [63:0] tx_reg;
  logic [31:0] rx_reg;
  logic [31:0] wdata_reg;
  logic [1:0] word_reg;
  logic wr_reg;
  logic [3:0] k_reg;
  logic [2:0] base_reg;
  logic cen_reg;
  logic [2:0] wid_reg;
  logic [31:0] key_reg [4];
  logic [31:0] ext_reg [4];
  logic [127:0] st_reg;
  logic [127:0] rk_reg;
  logic [7:0] rcon_reg;
  logic [3:0] round_reg;
  logic aes_run_reg;
  logic aes_done_reg;

  // Slot decode of the request
  wire [15:0] req_ctl = slot_control_in[xip_slot_in * SC_BITS +: SC_BITS];
  wire [2:0] req_wid = req_ctl[SC_WIDTH_LSB +: 3];
  wire [1:0] req_grp = req_ctl[SC_GROUP_LSB +: 2];
  wire req_cen = req_ctl[SC_CRYPT_BIT];
  wire req_wide = (req_wid == W_OCTAL) || (req_wid == W_DQUAD);
  wire bad_quad = (req_wid == W_QUAD) && (req_grp != LANE_GROUP_ZERO)
    && (req_grp != LANE_GROUP_TWO);
  wire bad_wide = req_wide && (req_grp != LANE_GROUP_ZERO);
  wire bad_pair = (req_wid == W_DQUAD) && xip_slot_in[0];
  wire req_bad = (req_wid > W_OCTAL) || bad_quad || bad_wide || bad_pair;
  wire idle = (state_reg == ST_IDLE);
  wire accept = idle && xip_req_in && !req_bad;
  wire refuse = idle && xip_req_in && req_bad;
  wire [3:0] req_k = lanes_of(req_wid);
  wire [2:0] req_base = {req_grp, 1'b0};
  wire [63:0] frame = {xip_write_in ? OP_WRITE : OP_READ, xip_addr_in[23:0], 32'h0000_0000};
  // Paired four-lane selects slot and its odd partner
  wire [3:0] sel_one = 4'h1 << xip_slot_in;
  wire [3:0] sel_mask = (req_wid == W_DQUAD) ? (sel_one | (sel_one << 1)) : sel_one;

  // Link clock edges from the synchronised interface clock
  wire ck_s = ck_sync_reg[1];
  wire ck_rise = ck_s && !ck_prev_reg;
  wire ck_fall = !ck_s && ck_prev_reg;
  wire do_rise = (state_reg == ST_RUN) && ck_rise && !sck_reg;
  wire do_fall = (state_reg == ST_RUN) && ck_fall && sck_reg;
  wire last = (cnt_reg == FRAME_BITS);
  wire in_read = !wr_reg && (cnt_reg >= HEAD_BITS);

  // Keystream word chosen by address bits 3:2
  wire [127:0] ct = st_reg;
  wire [31:0] ks_word = cen_reg ? ct[word_reg * 32 +: 32] : 32'h0000_0000;
  wire [31:0] tx_word = wdata_reg ^ ks_word;
  wire [31:0] rd_word = rx_reg ^ ks_word;
  wire [63:0] tx_next = (cnt_reg == HEAD_BITS) ? {tx_word, 32'h0000_0000} : (tx_reg << k_reg);
  wire [7:0] rx_bits = lane_gather(dq_sync_reg, k_reg, base_reg);
  wire [31:0] rx_next = (rx_reg << k_reg) | {24'h00_0000, rx_bits};
  wire data_out = wr_reg || (cnt_reg < HEAD_BITS);
  wire [7:0] lanes_next = lane_drive(tx_next[63:56], k_reg, base_reg);
  wire [7:0] mask_now = lane_mask(k_reg, base_reg);

  // Two-flop synchronisers for link clock and lanes
  always_ff @(posedge clk_in) begin
    ck_sync_reg <= {ck_sync_reg[0], if_clk_in};
    ck_prev_reg <= ck_sync_reg[1];
    dq_meta_reg <= dq_in;
    dq_sync_reg <= dq_meta_reg;
  end

  // Write-only key and cipher input extension registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        key_reg[i] <= EXT_RESET;
        ext_reg[i] <= EXT_RESET;
      end
    end else begin
      if (key_wr_in) key_reg[key_sel_in] <= key_data_in;
      if (ext_wr_in) ext_reg[ext_sel_in] <= ext_data_in;
    end
  end

  // Serial frame sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      sck_reg <= 1'b0;
      cs_n_reg <= 4'hf;
      dq_reg <= 8'h00;
      oe_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      cnt_reg <= 7'h00;
      tx_reg <= 64'h0000_0000_0000_0000;
      rx_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      word_reg <= 2'h0;
      wr_reg <= 1'b0;
      k_reg <= 4'h1;
      base_reg <= 3'h0;
      cen_reg <= 1'b0;
      wid_reg <= W_SINGLE;
    end else begin
      done_reg <= 1'b0;
      err_reg <= refuse;
      if (accept) begin
        state_reg <= ST_RUN;
        busy_reg <= 1'b1;
        cs_n_reg <= ~sel_mask;
        tx_reg <= frame;
        dq_reg <= lane_drive(frame[63:56], req_k, req_base);
        oe_reg <= lane_mask(req_k, req_base);
        cnt_reg <= 7'h00;
        wdata_reg <= xip_wdata_in;
        word_reg <= xip_addr_in[3:2];
        wr_reg <= xip_write_in;
        k_reg <= req_k;
        base_reg <= req_base;
        cen_reg <= req_cen;
        wid_reg <= req_wid;
      end
      if (do_rise) begin
        sck_reg <= 1'b1;
        if (in_read) rx_reg <= rx_next;
        cnt_reg <= cnt_reg + {3'h0, k_reg};
      end
      if (do_fall) begin
        sck_reg <= 1'b0;
        if (last) begin
          state_reg <= ST_IDLE;
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          cs_n_reg <= 4'hf;
          oe_reg <= 8'h00;
          if (!wr_reg) rdata_reg <= rd_word;
        end else begin
          tx_reg <= tx_next;
          dq_reg <= lanes_next;
          oe_reg <= data_out ? mask_now : 8'h00;
        end
      end
    end
  end

  // Cipher datapath, one round per clock
  wire [127:0] key_all = {key_reg[3], key_reg[2], key_reg[1], key_reg[0]};
  wire [127:0] plain = {ext_reg[3], ext_reg[2], ext_reg[1], xip_addr_in[31:4],
    ext_reg[0][3:0]};
  wire [31:0] w3 = rk_reg[31:0];
  wire [31:0] w3_rot = {w3[23:0], w3[31:24]};
  wire final_round = (round_reg == AES_ROUNDS);
  wire [7:0] sb_in [20];
  wire [7:0] sb_out [20];
  wire [7:0] sh [16];
  wire [127:0] mixed;

  genvar gi;
  generate
    for (gi = 0; gi < 20; gi++) begin : g_sbox
      if (gi < 16) begin : g_state
        assign sb_in[gi] = st_reg[127 - 8 * gi -: 8];
      end else begin : g_key
        assign sb_in[gi] = w3_rot[31 - 8 * (gi - 16) -: 8];
      end
      smlx_sbox u_sbox (
        .byte_in(sb_in[gi]),
        .byte_out(sb_out[gi])
      );
    end
    for (gi = 0; gi < 16; gi++) begin : g_shift
      assign sh[gi] = sb_out[4 * (((gi / 4) + (gi % 4)) % 4) + (gi % 4)];
    end
    for (gi = 0; gi < 4; gi++) begin : g_mix
      wire [7:0] a0 = sh[4 * gi];
      wire [7:0] a1 = sh[4 * gi + 1];
      wire [7:0] a2 = sh[4 * gi + 2];
      wire [7:0] a3 = sh[4 * gi + 3];
      wire [7:0] m0 = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
      wire [7:0] m1 = a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3;
      wire [7:0] m2 = a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3;
      wire [7:0] m3 = xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3);
      assign mixed[127 - 32 * gi -: 32] = final_round ? {a0, a1, a2, a3} : {m0, m1, m2, m3};
    end
  endgenerate

  wire [31:0] sub_rot = {sb_out[16], sb_out[17], sb_out[18], sb_out[19]};
  wire [31:0] n0 = rk_reg[127:96] ^ sub_rot ^ {rcon_reg, 24'h00_0000};
  wire [31:0] n1 = rk_reg[95:64] ^ n0;
  wire [31:0] n2 = rk_reg[63:32] ^ n1;
  wire [31:0] n3 = w3 ^ n2;
  wire [127:0] rk_next = {n0, n1, n2, n3};

  // Keystream starts with the request, well ahead of the data phase
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= KEY_RESET;
      rk_reg <= KEY_RESET;
      rcon_reg <= RCON_FIRST;
      round_reg <= 4'h0;
      aes_run_reg <= 1'b0;
      aes_done_reg <= 1'b0;
    end else begin
      aes_done_reg <= 1'b0;
      if (accept) begin
        st_reg <= plain ^ key_all;
        rk_reg <= key_all;
        rcon_reg <= RCON_FIRST;
        round_reg <= 4'h1;
        aes_run_reg <= 1'b1;
      end else if (aes_run_reg) begin
        st_reg <= mixed ^ rk_next;
        rk_reg <= rk_next;
        rcon_reg <= xt(rcon_reg);
        round_reg <= round_reg + 4'h1;
        if (final_round) begin
          aes_run_reg <= 1'b0;
          aes_done_reg <= 1'b1;
        end
      end
    end
  end

  assign xip_busy_out = busy_reg;
  assign xip_done_out = done_reg;
  assign xip_err_out = err_reg;
  assign xip_rdata_out = rdata_reg;
  assign sck_out = sck_reg;
  assign cs_n_out = cs_n_reg;
  assign dq_out = dq_reg;
  assign dq_oe_out = oe_reg;

  // Checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire [7:0] oe_low = oe_reg & (~oe_reg + 8'h01);
  wire [7:0] oe_fill = oe_reg + oe_low;

  chk_sck_idle_low: assert property ((&cs_n_reg) |-> !sck_reg)
    else $error("serial clock high while no slot selected");
  chk_sel_single: assert property ($countones(~cs_n_reg) <= 1 || wid_reg == W_DQUAD)
    else $error("more than one select asserted");
  chk_pair_sel: assert property (accept && req_wid == W_DQUAD
    |=> $countones(~cs_n_reg) == 2) else $error("paired mode lacks two selects");
  chk_data_on_fall: assert property ($changed(dq_reg) && !idle |-> !sck_reg)
    else $error("lane data changed with clock high");
  chk_bad_refused: assert property (refuse |=> err_reg && (&cs_n_reg) && !busy_reg)
    else $error("illegal lane group not refused");
  chk_lanes_contig: assert property ((oe_fill & oe_reg) == 8'h00)
    else $error("driven lanes not contiguous");
  chk_single_lane: assert property (!idle && k_reg == 4'h1
    |-> (oe_reg & ~(8'h01 << base_reg)) == 8'h00) else $error("single mode drives wrong lane");
  chk_cipher_time: assert property (accept |=> aes_run_reg [*8]
    ##1 aes_run_reg [*2] ##1 aes_done_reg) else $error("cipher round count wrong");
  chk_ks_ready: assert property (do_fall && cnt_reg == HEAD_BITS |-> !aes_run_reg)
    else $error("keystream not ready at data phase");
  chk_plain_read: assert property (do_fall && last && !wr_reg && !cen_reg
    |=> rdata_reg == $past(rx_reg)) else $error("read data altered with cipher off");
  chk_read_release: assert property (!idle && in_read && !sck_reg
    && cnt_reg > HEAD_BITS |-> oe_reg == 8'h00) else $error("lanes driven during read phase");

  cov_read: cover property (accept && !xip_write_in ##1 (!idle) [*8]);
  cov_write: cover property (accept && xip_write_in);
  cov_pair: cover property (accept && req_wid == W_DQUAD);
  cov_refuse: cover property (refuse);
endmodule // smlx_ctrl

// *** test/smlx_mem_model.sv ***
// Behavioural serial memory answering on one selected slot
`timescale 1ns/1ps
module smlx_mem_model (
  input wire logic sck_in,
  input wire logic [3:0] cs_n_in,
  input wire logic [7:0] dq_in,
  input wire logic [1:0] slot_in,
  input wire logic [3:0] k_in,
  input wire logic [2:0] obase_in,
  input wire logic [2:0] ibase_in,
  input wire logic write_in,
  input wire logic [31:0] word_in,
  output logic [7:0] dq_out,
  output logic [63:0] frame_out,
  output logic [6:0] bits_out
);
  logic [31:0] rd_reg;
  wire logic sel = !cs_n_in[slot_in];
  initial dq_out = 8'h5a;
  initial bits_out = 7'h0;
  always @(posedge sel) begin
    bits_out = 7'h0;
    rd_reg = word_in;
  end
  // Released lanes show the inverse of the last value
  always @(negedge sel) dq_out = ~dq_out;
  // Sample on rising serial clock, highest lane first
  always @(posedge sck_in) begin
    if (sel) begin
      for (int j = 7; j >= 0; j--)
        if (j < k_in) frame_out = {frame_out[62:0], dq_in[obase_in + j]};
      bits_out = bits_out + 7'(k_in);
    end
  end
  // Read data after the header, changed on falling serial clock
  always @(negedge sck_in) begin
    if (sel && !write_in && bits_out >= 7'h20 && bits_out < 7'h40) begin
      for (int j = 0; j < 8; j++)
        if (j < k_in) dq_out[ibase_in + j] = rd_reg[32 - k_in + j];
      rd_reg = rd_reg << k_in;
    end
  end
endmodule // smlx_mem_model

// *** test/tb.sv ***
// Self-checking bench of the serial memory lane controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb;
  import smlx_pkg::*;
  logic clk_in = 0, rst_in = 1, if_clk_in = 0, xip_req_in = 0, xip_write_in = 0;
  logic [1:0] xip_slot_in = 0, key_sel_in = 0, ext_sel_in = 0, m_slot = 0;
  logic [31:0] xip_addr_in = 0, xip_wdata_in = 0, key_data_in = 0, ext_data_in = 0;
  logic [63:0] slot_control_in = 0, m_frame;
  logic key_wr_in = 0, ext_wr_in = 0, m_wr = 0, sck_q = 0, e, b;
  logic xip_busy_out, xip_done_out, xip_err_out, sck_out;
  logic [31:0] xip_rdata_out, m_word = 0, c1;
  logic [3:0] cs_n_out, m_k = 1, seen = 0;
  logic [7:0] dq_out, dq_oe_out, m_dq;
  logic [2:0] m_ob = 0, m_ib = 0;
  logic [6:0] m_bits;
  int mismatches = 0, total_checks = 0, rises = 0, idle_bad = 0;
  int tk[5] = '{1, 2, 4, 8, 8};
  int tob[5] = '{2, 4, 4, 0, 0};
  int tib[5] = '{3, 4, 4, 0, 0};
  logic [1:0] ts[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic [1:0] tg[5] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
  logic [2:0] tw[5] = '{W_SINGLE, W_DUAL, W_QUAD, W_OCTAL, W_DQUAD};
  logic [3:0] tm[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
  logic [1:0] bs[4] = '{2'h2, 2'h2, 2'h1, 2'h3};
  logic [1:0] bg[4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  logic [2:0] bw[4] = '{W_QUAD, W_OCTAL, W_DQUAD, 3'h5};
  localparam logic [31:0] PW = 32'h1357_9bdf;
  // Resolved lane levels from the controller's enables; the memory drives the other lanes
  wire logic [7:0] lanes = (dq_oe_out & dq_out) | (~dq_oe_out & m_dq);

  smlx_ctrl smlx_ctrl_inst (.clk_in(clk_in), .rst_in(rst_in), .if_clk_in(if_clk_in),
    .xip_req_in(xip_req_in), .xip_write_in(xip_write_in), .xip_slot_in(xip_slot_in),
    .xip_addr_in(xip_addr_in), .xip_wdata_in(xip_wdata_in),
    .slot_control_in(slot_control_in), .key_wr_in(key_wr_in), .key_sel_in(key_sel_in),
    .key_data_in(key_data_in), .ext_wr_in(ext_wr_in), .ext_sel_in(ext_sel_in),
    .ext_data_in(ext_data_in), .dq_in(lanes), .xip_busy_out(xip_busy_out),
    .xip_done_out(xip_done_out), .xip_err_out(xip_err_out), .xip_rdata_out(xip_rdata_out),
    .sck_out(sck_out), .cs_n_out(cs_n_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out));
  smlx_mem_model smlx_mem_model_inst (.sck_in(sck_out), .cs_n_in(cs_n_out), .dq_in(lanes),
    .slot_in(m_slot), .k_in(m_k), .obase_in(m_ob), .ibase_in(m_ib), .write_in(m_wr),
    .word_in(m_word), .dq_out(m_dq), .frame_out(m_frame), .bits_out(m_bits));

  initial forever #2 clk_in = ~clk_in;
  initial begin
    #7.3;
    forever #40 if_clk_in = ~if_clk_in;
  end
  // Serial clock rises, selects seen, idle line levels
  always @(posedge clk_in) begin
    sck_q <= sck_out;
    if (sck_out && !sck_q) rises <= rises + 1;
    if (xip_busy_out) seen <= seen | ~cs_n_out;
    if (!rst_in && !xip_busy_out && (cs_n_out !== 4'hf || sck_out !== 1'b0))
      idle_bad <= idle_bad + 1;
  end

  task automatic access(input logic w, input logic [1:0] s, input logic [31:0] a,
                        input logic [31:0] d, input logic [3:0] mask, input int k);
    int n;
    n = 0;
    @(posedge clk_in);
    xip_req_in <= 1'b1;
    xip_write_in <= w;
    xip_slot_in <= s;
    xip_addr_in <= a;
    xip_wdata_in <= d;
    m_slot = s;
    m_wr = w;
    rises = 0;
    seen = 4'h0;
    @(posedge clk_in);
    xip_req_in <= 1'b0;
    while (xip_done_out !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK("done", 1'b1, xip_done_out)
    `CHK("head", {(w ? OP_WRITE : OP_READ), a[23:0]}, m_frame[63:32])
    `CHK("sck_rises", 64 / k, rises)
    `CHK("selects", mask, seen)
  endtask

  task automatic wr_aux(input logic [1:0] s, input logic [31:0] kd, input logic [31:0] ed);
    @(posedge clk_in);
    key_wr_in <= 1'b1;
    ext_wr_in <= 1'b1;
    key_sel_in <= s;
    ext_sel_in <= s;
    key_data_in <= kd;
    ext_data_in <= ed;
    @(posedge clk_in);
    key_wr_in <= 1'b0;
    ext_wr_in <= 1'b0;
  endtask

  task complete_run;
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_in);
    mismatches++;
    complete_run;
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    `CHK("cs_rst", 4'hf, cs_n_out)
    `CHK("rdata_rst", 32'h0000_0000, xip_rdata_out)
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      slot_control_in[16 * ts[i] +: 16] <= {7'h0, 1'b0, 2'h0, tg[i], 1'b0, tw[i]};
      m_k = 4'(tk[i]);
      m_ob = 3'(tob[i]);
      m_ib = 3'(tib[i]);
      access(1'b1, ts[i], 32'h0012_3450 + i, PW ^ i, tm[i], tk[i]);
      `CHK("wdata", PW ^ i, m_frame[31:0])
      m_word = 32'h3c5a_96e1 + i;
      access(1'b0, ts[i], 32'h0045_6780 + i, 32'h0000_0000, tm[i], tk[i]);
      `CHK("rdata", 32'h3c5a_96e1 + i, xip_rdata_out)
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      slot_control_in[16 * bs[i] +: 16] <= {7'h0, 1'b0, 2'h0, bg[i], 1'b0, bw[i]};
      xip_slot_in <= bs[i];
      xip_req_in <= 1'b1;
      @(posedge clk_in);
      xip_req_in <= 1'b0;
      #1;
      e = xip_err_out;
      b = xip_busy_out;
      repeat (3) begin
        @(posedge clk_in);
        #1;
        e = e | xip_err_out;
        b = b | xip_busy_out;
      end
      `CHK("illegal_err", 1'b1, e)
      `CHK("illegal_busy", 1'b0, b)
    end
    for (int i = 0; i < 4; i++) begin
      wr_aux(2'(i), 32'h1111_1111 * (i + 1), 32'h0f0f_0000 + i);
    end
    @(posedge clk_in);
    slot_control_in[47:32] <= {7'h0, 1'b1, 2'h0, 2'h2, 1'b0, W_QUAD};
    m_k = 4'h4;
    m_ob = 3'h4;
    m_ib = 3'h4;
    access(1'b1, 2'h2, 32'h0000_0a40, PW, 4'h4, 4);
    c1 = m_frame[31:0];
    `CHK("cipher_on", 1'b1, c1 !== PW)
    m_word = c1;
    access(1'b0, 2'h2, 32'h0000_0a40, 32'h0000_0000, 4'h4, 4);
    `CHK("decrypt", PW, xip_rdata_out)
    access(1'b1, 2'h2, 32'h0010_0a40, PW, 4'h4, 4);
    `CHK("addr_used", 1'b1, m_frame[31:0] !== c1)
    wr_aux(2'h0, 32'h7777_0000, 32'h0f0f_0000);
    access(1'b1, 2'h2, 32'h0000_0a40, PW, 4'h4, 4);
    `CHK("key_used", 1'b1, m_frame[31:0] !== c1)
    `CHK("idle_lines", 0, idle_bad)
    complete_run;
  end
endmodule // tb
